//--- verilog/reconfig_user.sv
module reconfig_user #(
	parameter int IMG_DEPTH = 64
) (
	input wire logic clock_i,
	input wire logic rst_i,
	reconfig_if.user link,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	import reconfig_pkg::*;

	typedef enum logic [1:0] {MODE_8, MODE_10, MODE_16, MODE_20} width_type;

	logic [WORD_W-1:0] image [IMG_DEPTH];
	logic [IMG_AW-1:0] image_wr_ptr;
	logic continuous;
	logic [CHAN_SEL_W-1:0] chan_sel;
	logic [IMG_AW:0] word_count;
	logic go_pending;
	logic strobe;
	logic pcie_mode;
	logic [1:0] width_sel;
	logic [TX_FULL_W-1:0] packed_word;
	logic [TX_FULL_W-1:0] next_packed;
	logic push;
	logic [$clog2(FIFO_DEPTH):0] level;
	logic fifo_in_ready;
	logic ack;

	////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle then answer, except stalled tx pushes
	assign push = avs_write_i && (avs_address_i == TXDATA_ADDR);
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read_i || avs_write_i) && !ack && (!push || fifo_in_ready);
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			continuous <= 1'b0;
			chan_sel <= '0;
			word_count <= '0;
			image_wr_ptr <= '0;
			go_pending <= 1'b0;
			pcie_mode <= 1'b0;
			width_sel <= '0;
		end else begin
			if (strobe) begin
				go_pending <= 1'b0;
			end
			if (avs_write_i && ack) begin
				case (avs_address_i)
					CTRL_ADDR: begin
						continuous <= avs_writedata_i[CTRL_CONT_BIT];
						chan_sel <= avs_writedata_i[CTRL_CHAN_LSB +: CHAN_SEL_W];
						word_count <= avs_writedata_i[CTRL_COUNT_LSB +: IMG_AW+1];
						pcie_mode <= avs_writedata_i[CTRL_PCIE_BIT];
						width_sel <= avs_writedata_i[CTRL_WIDTH_LSB +: 2];
						image_wr_ptr <= '0;
						if (avs_writedata_i[CTRL_GO_BIT]) begin
							go_pending <= 1'b1;
						end
					end
					IMAGE_ADDR: begin
						image_wr_ptr <= image_wr_ptr + 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (avs_write_i && ack && avs_address_i == IMAGE_ADDR) begin
			image[image_wr_ptr] <= avs_writedata_i[WORD_W-1:0];
		end
	end

	always_comb begin
		case (avs_address_i)
			CTRL_ADDR: avs_readdata_o = {6'h00, width_sel, 9'h000, word_count,
				chan_sel, 1'b0, pcie_mode, continuous, go_pending};
			STATUS_ADDR: avs_readdata_o = {9'h000, 1'b0, link.image_addr,
				2'b00, level, 7'h00, link.busy};
			IMAGE_ADDR: avs_readdata_o = {16'h0000, image[image_wr_ptr]};
			TXDATA_ADDR: avs_readdata_o = {16'h0000, link.rx_full[WORD_W-1:0]};
			default: avs_readdata_o = UNMAPPED_DATA;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// one-cycle broadcast strobe, only when the controller is idle
	assign strobe = go_pending && !link.busy; // R16 R18
	assign link.write_all = strobe;
	assign link.read_req = 1'b0; // R2
	assign link.continuous = continuous;
	assign link.chan_sel = chan_sel;
	assign link.word_count = word_count;
	assign link.image_word = image[link.image_addr];

	////////////////////////////////////////////////////////////////
	// pack register word into the 22-bit transmit lane
	// writedata: [7:0] lo byte or [9:0] lo sym, [15:8] hi byte or [19:10] hi sym, [17:16] ctrl, [19:18] disp en, [21:20] disp val
	always_comb begin
		next_packed = '0;
		case (width_type'(width_sel))
			MODE_8: begin
				next_packed[LO_BYTE_LSB +: BYTE_W] = avs_writedata_i[7:0]; // R8
				next_packed[LO_CTRL_BIT] = avs_writedata_i[16]; // R8
				next_packed[LO_DISP_EN_BIT] = avs_writedata_i[18]; // R9
				next_packed[LO_DISP_VAL_BIT] = avs_writedata_i[20]; // R10
			end
			MODE_10: begin
				next_packed[LO_BYTE_LSB +: SYM10_W] = avs_writedata_i[9:0]; // R11
			end
			MODE_16: begin
				next_packed[LO_BYTE_LSB +: BYTE_W] = avs_writedata_i[7:0]; // R12
				next_packed[HI_SYM_LSB +: BYTE_W] = avs_writedata_i[15:8]; // R12
				next_packed[LO_CTRL_BIT] = avs_writedata_i[16]; // R13
				next_packed[HI_CTRL_BIT] = avs_writedata_i[17]; // R13
				next_packed[LO_DISP_EN_BIT] = avs_writedata_i[18]; // R14
				next_packed[HI_DISP_EN_BIT] = pcie_mode ? 1'b0 : avs_writedata_i[19]; // R14
				next_packed[LO_DISP_VAL_BIT] = avs_writedata_i[20]; // R15
				next_packed[HI_DISP_VAL_BIT] = pcie_mode ? avs_writedata_i[20]
					: avs_writedata_i[21]; // R15
			end
			MODE_20: begin
				next_packed[LO_BYTE_LSB +: SYM10_W] = avs_writedata_i[9:0]; // R11
				next_packed[HI_SYM_LSB +: SYM10_W] = avs_writedata_i[19:10]; // R11
			end
			default: begin
				next_packed = '0;
			end
		endcase
	end

	assign packed_word = next_packed;

	word_fifo #(.WIDTH(TX_FULL_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.in_data_i(packed_word),
		.in_valid_i(push && ack),
		.in_ready_o(fifo_in_ready),
		.out_data_o(link.tx_full),
		.out_valid_o(link.tx_full_valid),
		.out_ready_i(link.tx_full_ready),
		.level_o(level)
	);
endmodule // reconfig_user

//--- verilog/reconfig_pkg.sv
package reconfig_pkg;
	localparam int WORD_W = 16;
	localparam int TX_FULL_W = 22;
	localparam int RX_FULL_W = 32;
	localparam int CHAN_SEL_W = 4;
	localparam int IMG_AW = 6;
	localparam int FIFO_DEPTH = 32;
	// transmit bus field positions
	localparam int LO_BYTE_LSB = 0;
	localparam int LO_CTRL_BIT = 8;
	localparam int LO_DISP_EN_BIT = 9;
	localparam int LO_DISP_VAL_BIT = 10;
	localparam int HI_SYM_LSB = 11;
	localparam int HI_CTRL_BIT = 19;
	localparam int HI_DISP_EN_BIT = 20;
	localparam int HI_DISP_VAL_BIT = 21;
	localparam int SYM10_W = 10;
	localparam int BYTE_W = 8;
	// Avalon register map (byte addresses)
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h4;
	localparam logic [3:0] IMAGE_ADDR = 4'h8;
	localparam logic [3:0] TXDATA_ADDR = 4'hC;
	// control and status register fields
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_CONT_BIT = 1;
	localparam int CTRL_PCIE_BIT = 2;
	localparam int CTRL_CHAN_LSB = 4;
	localparam int CTRL_WIDTH_LSB = 24;
	localparam int CTRL_COUNT_LSB = 8;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_LEVEL_LSB = 8;
	localparam int STATUS_DONE_LSB = 16;
	localparam logic [31:0] UNMAPPED_DATA = 32'hDEADBEEF;
endpackage

//--- verilog/reconfig_if.sv
interface reconfig_if;
	import reconfig_pkg::*;
	logic write_all;
	logic read_req;
	logic continuous;
	logic [CHAN_SEL_W-1:0] chan_sel;
	logic [WORD_W-1:0] image_word;
	logic [IMG_AW-1:0] image_addr;
	logic [IMG_AW:0] word_count;
	logic busy;
	logic [TX_FULL_W-1:0] tx_full;
	logic tx_full_valid;
	logic tx_full_ready;
	logic [RX_FULL_W-1:0] rx_full;
	modport device (
		input write_all, read_req, continuous, chan_sel, image_word, word_count,
		input tx_full, tx_full_valid,
		output image_addr, busy, tx_full_ready, rx_full
	);
	modport user (
		output write_all, read_req, continuous, chan_sel, image_word, word_count,
		output tx_full, tx_full_valid,
		input image_addr, busy, tx_full_ready, rx_full
	);
endinterface

//--- verilog/word_fifo.sv
module word_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 32
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_ptr];
	assign level_o = count;

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // word_fifo

//--- verilog/reconfig_ctrl.sv
// How it works
// R1: rewrite channel PCS and receive settings live
// R2: only writes accepted; reads ignored
// R3: continuous option: one strobe writes whole image
// R4: image moves as 16-bit words
// R5: interface width and signal set change
// R6: transmit bus is 22 bits
// R7: receive bus is 32 bits
// R8: 8-bit: byte [7:0], control flag [8]
// R9: bit [9] disparity force or compliance
// R10: bit [10] disparity value or idle
// R11: symbols on [9:0] and [20:11]
// R12: 16-bit bytes on [7:0], [18:11]
// R13: control flags on [8] and [19]
// R14: force enables [9],[20]; PCIe [20] zero
// R15: disparity values [10],[21]; PCIe idle both
// R16: user checks busy low before writing
// R17: busy high while write in progress
// R18: write strobe lasts one cycle
// R19: continuous: busy until last word written
module reconfig_ctrl #(
	parameter int IMG_DEPTH = 64,
	parameter int NUM_CHANNELS = 4
) (
	input wire logic clock_i,
	input wire logic rst_i,
	reconfig_if.device link,
	output logic [reconfig_pkg::WORD_W-1:0] chan_word_o,
	output logic [reconfig_pkg::IMG_AW-1:0] chan_addr_o,
	output logic [reconfig_pkg::CHAN_SEL_W-1:0] chan_sel_o,
	output logic chan_we_o,
	output logic [reconfig_pkg::TX_FULL_W-1:0] tx_lane_o,
	output logic tx_lane_valid_o,
	input wire logic tx_lane_ready_i,
	input wire logic [reconfig_pkg::RX_FULL_W-1:0] rx_lane_i,
	output logic [reconfig_pkg::IMG_AW:0] words_done_o
);
	import reconfig_pkg::*;

	typedef enum logic [1:0] {IDLE, WRITING} ctrl_state_type;
	ctrl_state_type state;
	logic cont_mode;
	logic [IMG_AW:0] target;
	logic [IMG_AW-1:0] addr;
	logic [IMG_AW:0] done_count;
	logic last_word;
	logic start;

	////////////////////////////////////////////////////////////////
	// write sequencer; a read request never starts anything
	assign last_word = (cont_mode ? (done_count + 1'b1 >= target) : 1'b1);
	// the last word still counts as busy, so a strobe in that cycle is refused
	assign start = (state == IDLE) && !chan_we_o && link.write_all && !link.read_req;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state <= IDLE;
			cont_mode <= 1'b0;
			target <= '0;
			addr <= '0;
			chan_sel_o <= '0;
		end else begin
			case (state)
				IDLE: begin
					if (start) begin // R2 R18
						cont_mode <= link.continuous; // R3
						target <= link.word_count;
						addr <= link.continuous ? '0 : addr;
						chan_sel_o <= link.chan_sel;
						state <= WRITING; // R17
					end
				end
				WRITING: begin
					addr <= addr + 1'b1; // R4
					if (last_word) begin
						state <= IDLE; // R19
					end
				end
				default: begin
					state <= IDLE;
				end
			endcase
		end
	end

	// word counter shows image progress; clears to zero on each new transfer
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			done_count <= '0;
		end else if (start) begin
			done_count <= '0;
		end else if (state == WRITING) begin
			done_count <= done_count + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// channel write port: one 16-bit image word per cycle
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			chan_word_o <= '0;
			chan_addr_o <= '0;
			chan_we_o <= 1'b0;
		end else begin
			chan_we_o <= (state == WRITING); // R1 R4
			chan_word_o <= link.image_word;
			chan_addr_o <= addr;
		end
	end

	assign link.image_addr = addr;
	assign link.busy = (state != IDLE) || chan_we_o; // R17 R19
	assign words_done_o = done_count;

	////////////////////////////////////////////////////////////////
	// wide data paths are always connected, alongside the narrow channel write port; no mode gates them
	assign tx_lane_o = link.tx_full; // R5 R6
	assign tx_lane_valid_o = link.tx_full_valid;
	assign link.tx_full_ready = tx_lane_ready_i;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			link.rx_full <= '0;
		end else begin
			link.rx_full <= rx_lane_i; // R7
		end
	end
endmodule // reconfig_ctrl

//--- testbench/reconfig_props.sv
module reconfig_props (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic write_all,
	input wire logic read_req,
	input wire logic continuous,
	input wire logic busy,
	input wire logic [reconfig_pkg::IMG_AW-1:0] image_addr,
	input wire logic [reconfig_pkg::IMG_AW:0] word_count,
	input wire logic [reconfig_pkg::TX_FULL_W-1:0] tx_full,
	input wire logic tx_full_valid,
	input wire logic tx_full_ready
);
	import reconfig_pkg::*;
	logic [7:0] len;
	logic [7:0] want;
	logic cont;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	// busy length: a zero count still writes one word
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) len <= 8'h00;
		else len <= busy ? len + 8'h01 : 8'h00;
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			want <= 8'h00;
			cont <= 1'b0;
		end else if (write_all && !busy) begin
			want <= (word_count == 0 ? 8'h01 : {1'b0, word_count}) + 8'h01;
			cont <= continuous;
		end
	end
	////////////////////////////////////////////////////////////////
	a_no_read: assert property (!read_req)
		else $error("read request in channel mode");
	a_one_strobe: assert property (write_all |=> !write_all)
		else $error("write strobe longer than one cycle");
	a_idle_start: assert property (write_all |-> !busy)
		else $error("write strobe while busy");
	a_busy_rise: assert property (write_all |=> busy)
		else $error("busy not raised after strobe");
	a_busy_ends: assert property ($rose(busy) |-> ##[1:140] !busy)
		else $error("busy never dropped");
	a_cont_addr: assert property ($rose(busy) && continuous |-> image_addr == '0)
		else $error("continuous write not from word 0");
	a_cont_len: assert property ($fell(busy) && cont |-> $past(len) + 8'h01 == want)
		else $error("busy length wrong for word count");
	a_tx_hold: assert property (tx_full_valid && !tx_full_ready |=>
		tx_full_valid && $stable(tx_full))
		else $error("transmit word dropped while stalled");
endmodule // reconfig_props

//--- testbench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import reconfig_pkg::*;
	logic clock_i, rst_i, rd, wr, wait_o, ready, we;
	logic [3:0] addr;
	logic [31:0] wd, rdata, rv;
	logic [31:0] rx;
	logic [WORD_W-1:0] word;
	logic [IMG_AW-1:0] waddr;
	logic [CHAN_SEL_W-1:0] sel;
	logic [TX_FULL_W-1:0] tx;
	logic txv;
	logic [IMG_AW:0] done;
	logic [WORD_W-1:0] mem [64];
	int err_total, num_checks, nwe, pops, waits, cyc;
	reconfig_if link_if();
	reconfig_user i_reconfig_user (.clock_i(clock_i), .rst_i(rst_i), .link(link_if),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wait_o));
	reconfig_ctrl i_reconfig_ctrl (.clock_i(clock_i), .rst_i(rst_i), .link(link_if),
		.chan_word_o(word), .chan_addr_o(waddr), .chan_sel_o(sel), .chan_we_o(we),
		.tx_lane_o(tx), .tx_lane_valid_o(txv), .tx_lane_ready_i(ready), .rx_lane_i(rx),
		.words_done_o(done));
	reconfig_props i_reconfig_props (.clock_i(clock_i), .rst_i(rst_i),
		.write_all(link_if.write_all), .read_req(link_if.read_req),
		.continuous(link_if.continuous), .busy(link_if.busy), .image_addr(link_if.image_addr),
		.word_count(link_if.word_count), .tx_full(link_if.tx_full),
		.tx_full_valid(link_if.tx_full_valid), .tx_full_ready(link_if.tx_full_ready));
	always #4 clock_i = ~clock_i;
	////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
			err_total++;
		end
	endtask
	// one Avalon access; holds until waitrequest is seen low
	task automatic av(logic [3:0] a, logic w, logic [31:0] d);
		addr <= a;
		rd <= !w;
		wr <= w;
		wd <= d;
		waits = 0;
		do begin
			@(posedge clock_i);
			waits++;
		end while (wait_o !== 1'b0);
		rv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic idle;
		repeat (3) @(posedge clock_i);
		do av(STATUS_ADDR, 0, 0); while (rv[0] !== 1'b0);
	endtask
	always @(posedge clock_i) begin
		if (we === 1'b1) begin
			mem[waddr] = word;
			nwe++;
		end
		if (txv === 1'b1 && ready === 1'b1) pops++;
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		clock_i = 0;
		rst_i = 1;
		{addr, rd, wr, wd, ready} = '0;
		rx = 32'h5A5AC3C3;
		repeat (10) @(posedge clock_i);
		rst_i <= 0;
		@(posedge clock_i);
		av(STATUS_ADDR, 0, 0);
		chk("status", 32'h0, rv);
		av(4'h1, 1, 32'h1);
		av(4'h1, 0, 0);
		chk("unmapped", UNMAPPED_DATA, rv);
		av(TXDATA_ADDR, 0, 0);
		chk("rx", 32'hC3C3, {16'h0, rv[15:0]});
		av(CTRL_ADDR, 1, 0);
		for (int i = 0; i < 3; i++) av(IMAGE_ADDR, 1, 32'hA100 + i);
		av(CTRL_ADDR, 1, 32'h353);
		idle();
		chk("words", 3, nwe);
		for (int i = 0; i < 3; i++) chk("word", 32'hA100 + i, mem[i]);
		chk("sel", 5, sel);
		chk("done", 3, done);
		av(CTRL_ADDR, 1, 32'h51);
		idle();
		chk("regular", 4, nwe);
		chk("done1", 1, done);
		// 16-bit lanes, then the same word in PCIe mode
		av(CTRL_ADDR, 1, 32'h2000000);
		av(TXDATA_ADDR, 1, 32'h1EA53C);
		chk("tx16", 32'h1D2E3C, tx);
		ready <= 1;
		@(posedge clock_i);
		ready <= 0;
		av(CTRL_ADDR, 1, 32'h2000004);
		av(TXDATA_ADDR, 1, 32'h1EA53C);
		chk("txpcie", 32'h2D2E3C, tx);
		for (int i = 1; i < 32; i++) av(TXDATA_ADDR, 1, i);
		av(STATUS_ADDR, 0, 0);
		chk("full", 32, rv[13:8]);
		fork
			av(TXDATA_ADDR, 1, 32'h77);
			begin
				repeat (20) @(posedge clock_i);
				ready <= 1;
			end
		join
		chk("stall", 1, waits > 20);
		repeat (40) @(posedge clock_i);
		chk("pops", 34, pops);
		av(STATUS_ADDR, 0, 0);
		chk("empty", 0, rv[13:8]);
		// remaining lane widths, one word each, popped after the compare
		ready <= 0;
		av(CTRL_ADDR, 1, 32'h0);
		av(TXDATA_ADDR, 1, 32'h1500A5);
		chk("tx8", 32'h7A5, tx);
		chk("txv", 1, txv);
		chk("nogo", 4, nwe);
		ready <= 1;
		@(posedge clock_i);
		ready <= 0;
		av(CTRL_ADDR, 1, 32'h1000000);
		av(TXDATA_ADDR, 1, 32'hF2CB);
		chk("tx10", 32'h2CB, tx);
		ready <= 1;
		@(posedge clock_i);
		ready <= 0;
		av(CTRL_ADDR, 1, 32'h3000000);
		av(TXDATA_ADDR, 1, 32'h34D6CB);
		chk("tx20", 32'h9AACB, tx);
		ready <= 1;
		@(posedge clock_i);
		ready <= 0;
		@(posedge clock_i);
		chk("pops2", 37, pops);
		finish_test();
	end
endmodule // tb
